// ==== rtl/gcsm_defines.vh ====
// Overview of operation
// - both clock inputs use identical switchover and protection logic.
// - reset-delay pin strapped high disables the guard; plain immediate multiplexing.
// - selected input below minimum swing makes output hold last valid level.
// - running clocks: follow old briefly, park low on new pulses, follow new.
// - old stuck high: stay high some new pulses, then low, then follow new.
// - stretched cycle high and low portions each exceed half the new period.
// - old stuck low: stay low some new falling edges, then follow new.
// - collapsed old clock switches as stuck high or low by last valid level.
// - failed selected input never gives an undefined or ringing output level.
// - slowly degrading yet toggling input is not cleaned of runts.
// - stage pulse counts vary within limits due to asynchronous sampling.
// - power-up reset holds switchover logic until supply stable, known start.
// - guarded switch length follows new clock edges; a dead new clock leaves it waiting after select change.
`ifndef GCSM_DEFINES_VH
`define GCSM_DEFINES_VH

// ****************************************
// timing
// ****************************************
`define GCSM_CLK_PERIOD_NS 10
// power-up hold time in ns and its cycle count, sized for the 16 bit counter
`define GCSM_POR_TIME_NS 100000
`define GCSM_POR_CYCLES 16'h2710
// no edge for this long marks an input as stuck, sized for the 8 bit counter
`define GCSM_STUCK_TIME_NS 640
`define GCSM_STUCK_CYCLES 8'h40

// ****************************************
// switchover sequence counts
// ****************************************
`define GCSM_HOLD_EDGES 3'h2
`define GCSM_PARK_EDGES 3'h2
`define GCSM_LAST_SWITCH_CYCLE 17

// ****************************************
// synchroniser bank bit positions
// ****************************************
`define GCSM_SYNC_W 5
`define GCSM_BIT_CLK_A 0
`define GCSM_BIT_CLK_B 1
`define GCSM_BIT_AMP_A 2
`define GCSM_BIT_AMP_B 3
`define GCSM_BIT_SEL 4

`endif

// ==== rtl/gcsm_sync.v ====
`timescale 1ns/1ps
`include "gcsm_defines.vh"

module gcsm_sync (
   // clock and reset
   input wire clk_sys_i,
   input wire sys_rst_i,
   // asynchronous levels in, synchronised levels out
   input wire [`GCSM_SYNC_W-1:0] async_i,
   output wire [`GCSM_SYNC_W-1:0] sync_o
);

   // ****************************************
   // two-stage synchronisers, one per bit
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < `GCSM_SYNC_W; gi = gi + 1) begin : g_bit
         reg meta_reg;
         reg stable_reg;
         // first stage feeds only the second stage
         always @(posedge clk_sys_i) begin
            if (sys_rst_i) begin
               meta_reg <= 1'b0;
               stable_reg <= 1'b0;
            end else begin
               meta_reg <= async_i[gi];
               stable_reg <= meta_reg;
            end
         end
         assign sync_o[gi] = stable_reg;
      end
   endgenerate

endmodule // gcsm_sync

// ==== rtl/gcsm_fail_mon.v ====
`timescale 1ns/1ps
`include "gcsm_defines.vh"

module gcsm_fail_mon (
   // clock and reset
   input wire clk_sys_i,
   input wire sys_rst_i,
   // synchronised clock level and amplitude good flag
   input wire lvl_i,
   input wire amp_ok_i,
   // edge pulses, failure and last valid level
   output wire rise_o,
   output wire fall_o,
   output wire failed_o,
   output wire last_lvl_o
);

   localparam [7:0] STUCK_CYC = `GCSM_STUCK_CYCLES;

   reg prev_reg;
   reg last_reg;
   reg [7:0] idle_cnt_reg;
   reg stuck_reg;

   // edges only count while the swing is good
   // toggling input still followed
   assign rise_o = amp_ok_i & lvl_i & ~prev_reg;
   assign fall_o = amp_ok_i & ~lvl_i & prev_reg;
   // either a dead amplitude or no edges marks the input failed
   assign failed_o = ~amp_ok_i | stuck_reg;
   assign last_lvl_o = last_reg;

   // ****************************************
   // activity watchdog and last valid level
   // ****************************************
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         prev_reg <= 1'b0;
         last_reg <= 1'b0;
         idle_cnt_reg <= 8'h00;
         stuck_reg <= 1'b0;
      end else begin
         prev_reg <= lvl_i;
         if (amp_ok_i) begin
            last_reg <= lvl_i;
         end
         if (rise_o | fall_o) begin
            idle_cnt_reg <= 8'h00;
            stuck_reg <= 1'b0;
         end else if (idle_cnt_reg == STUCK_CYC) begin
            stuck_reg <= 1'b1; // saturates until the next edge
         end else begin
            idle_cnt_reg <= idle_cnt_reg + 8'h01;
         end
      end
   end

endmodule // gcsm_fail_mon

// ==== rtl/gcsm_top.v ====
`timescale 1ns/1ps
`include "gcsm_defines.vh"

module gcsm_top #(
   parameter [15:0] POR_CYCLES = `GCSM_POR_CYCLES
) (
   // system clock and reset
   input wire clk_sys_i,
   input wire sys_rst_i,
   // clock sources, asynchronous
   input wire clock_input_a_i,
   input wire clock_input_b_i,
   // amplitude comparators, high while swing is above the minimum
   input wire amp_ok_a_i,
   input wire amp_ok_b_i,
   // select, low picks input a, asynchronous
   input wire select_i,
   // strap, high disables the runt pulse guard
   input wire reset_delay_pin_i,
   // multiplexed clock output
   output wire clock_out_o,
   // status
   output wire active_input_o,
   output wire switching_o,
   output wire failed_a_o,
   output wire failed_b_o,
   output wire por_busy_o
);

   // ****************************************
   // states of the switchover sequence
   // ****************************************
   // plain binary codes; unused codes fall back to run
   localparam [2:0] ST_RUN = 3'h0;
   localparam [2:0] ST_TAIL = 3'h1;
   localparam [2:0] ST_HOLDHI = 3'h2;
   localparam [2:0] ST_DROP = 3'h3;
   localparam [2:0] ST_PARK = 3'h4;

   wire [`GCSM_SYNC_W-1:0] async_bank;
   wire [`GCSM_SYNC_W-1:0] sync_bank;
   wire lvl_a;
   wire lvl_b;
   wire rise_a;
   wire rise_b;
   wire fall_a;
   wire fall_b;
   wire fail_a;
   wire fail_b;
   wire last_a;
   wire last_b;
   wire sel_s;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg sel_cur_reg;
   reg sel_cur_next;
   reg out_reg;
   reg out_next;
   reg [2:0] cnt_reg;
   reg [2:0] cnt_next;
   reg [15:0] por_cnt_reg;
   reg por_busy_reg;
   reg guard_off_reg;
   reg guard_meta_reg;
   reg switching_reg;
   reg fail_a_reg;
   reg fail_b_reg;

   // old and new views of the two inputs
   reg old_lvl;
   reg old_fall;
   reg old_fail;
   reg old_last;
   reg new_rise;
   reg new_fall;
   reg sel_lvl;
   reg sel_fail;

   // ****************************************
   // input synchronisers
   // ****************************************
   assign async_bank[`GCSM_BIT_CLK_A] = clock_input_a_i;
   assign async_bank[`GCSM_BIT_CLK_B] = clock_input_b_i;
   assign async_bank[`GCSM_BIT_AMP_A] = amp_ok_a_i;
   assign async_bank[`GCSM_BIT_AMP_B] = amp_ok_b_i;
   assign async_bank[`GCSM_BIT_SEL] = select_i;

   gcsm_sync u_sync (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .async_i(async_bank),
      .sync_o(sync_bank)
   );

   assign lvl_a = sync_bank[`GCSM_BIT_CLK_A];
   assign lvl_b = sync_bank[`GCSM_BIT_CLK_B];
   assign sel_s = sync_bank[`GCSM_BIT_SEL];

   // ****************************************
   // per-input failure monitors
   // ****************************************
   // identical monitor instances
   gcsm_fail_mon u_mon_a (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .lvl_i(lvl_a),
      .amp_ok_i(sync_bank[`GCSM_BIT_AMP_A]),
      .rise_o(rise_a),
      .fall_o(fall_a),
      .failed_o(fail_a),
      .last_lvl_o(last_a)
   );

   gcsm_fail_mon u_mon_b (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .lvl_i(lvl_b),
      .amp_ok_i(sync_bank[`GCSM_BIT_AMP_B]),
      .rise_o(rise_b),
      .fall_o(fall_b),
      .failed_o(fail_b),
      .last_lvl_o(last_b)
   );

   // ****************************************
   // power-up hold and strap capture
   // ****************************************
   // strap is caught by a clocked process, not by the reset itself
   // strap is a pin, so it passes two stages like select; static, so latency is harmless
   // power-up hold
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         por_cnt_reg <= 16'h0000;
         por_busy_reg <= 1'b1;
         guard_meta_reg <= 1'b0;
         guard_off_reg <= 1'b0;
      end else begin
         guard_meta_reg <= reset_delay_pin_i;
         guard_off_reg <= guard_meta_reg;
         if (por_cnt_reg == POR_CYCLES) begin
            por_busy_reg <= 1'b0;
         end else begin
            por_cnt_reg <= por_cnt_reg + 16'h0001;
         end
      end
   end

   // ****************************************
   // old and new input selection
   // ****************************************
   // one mux per role keeps both inputs alike
   // symmetric roles by sel_cur
   always @* begin
      old_lvl = sel_cur_reg ? lvl_b : lvl_a;
      old_fall = sel_cur_reg ? fall_b : fall_a;
      old_fail = sel_cur_reg ? fail_b : fail_a;
      old_last = sel_cur_reg ? last_b : last_a;
      new_rise = sel_cur_reg ? rise_a : rise_b;
      new_fall = sel_cur_reg ? fall_a : fall_b;
      sel_lvl = sel_s ? lvl_b : lvl_a;
      sel_fail = sel_s ? fail_b : fail_a;
   end

   // ****************************************
   // switchover sequence
   // ****************************************
   // counts vary with sampling phase
   always @* begin
      state_next = state_reg;
      sel_cur_next = sel_cur_reg;
      out_next = out_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         ST_RUN: begin
            if (guard_off_reg) begin
               sel_cur_next = sel_s;
               if (!sel_fail) begin
                  out_next = sel_lvl;
               end
            end else if (sel_s != sel_cur_reg) begin
               // a change made during a switchover is taken here on return
               cnt_next = 3'h0;
               if (old_fail) begin
                  state_next = old_last ? ST_HOLDHI : ST_PARK;
                  out_next = old_last;
               end else begin
                  state_next = ST_TAIL;
                  out_next = old_lvl;
               end
            end else if (!old_fail) begin
               out_next = old_lvl;
            end
         end
         ST_TAIL: begin
            if (old_fall) begin
               out_next = 1'b0;
               state_next = ST_PARK;
            end else if (old_fail) begin
               out_next = old_last;
               state_next = old_last ? ST_HOLDHI : ST_PARK;
            end else begin
               out_next = old_lvl;
            end
         end
         ST_HOLDHI: begin
            // a dead new clock leaves the output high here
            // high for new rising edges
            out_next = 1'b1;
            if (new_rise) begin
               cnt_next = cnt_reg + 3'h1;
               if (cnt_reg == `GCSM_HOLD_EDGES - 3'h1) begin
                  state_next = ST_DROP;
               end
            end
         end
         ST_DROP: begin
            // waiting for a fall keeps the low half whole
            // drop only on a new falling edge
            if (new_fall) begin
               out_next = 1'b0;
               cnt_next = 3'h0;
               state_next = ST_PARK;
            end
         end
         ST_PARK: begin
            // a dead new clock leaves the sequence waiting here
            // low for new falling edges
            out_next = 1'b0;
            if (new_fall) begin
               cnt_next = cnt_reg + 3'h1;
               if (cnt_reg == `GCSM_PARK_EDGES - 3'h1) begin
                  sel_cur_next = ~sel_cur_reg;
                  state_next = ST_RUN;
               end
            end
         end
         default: begin
            state_next = ST_RUN;
            out_next = 1'b0;
         end
      endcase
   end

   // sequence registers, held parked during the power-up hold
   // busy phase tracks select so the first switch starts from it
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         state_reg <= ST_RUN;
         sel_cur_reg <= 1'b0;
         out_reg <= 1'b0;
         cnt_reg <= 3'h0;
      end else if (por_busy_reg) begin
         state_reg <= ST_RUN;
         sel_cur_reg <= sel_s;
         out_reg <= 1'b0;
         cnt_reg <= 3'h0;
      end else begin
         state_reg <= state_next;
         sel_cur_reg <= sel_cur_next;
         out_reg <= out_next;
         cnt_reg <= cnt_next;
      end
   end

   // ****************************************
   // registered status outputs
   // ****************************************
   // switching flag built from the next state, so it stays aligned with the state
   // failure flags lag the monitors by one cycle, harmless for status
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         switching_reg <= 1'b0;
         fail_a_reg <= 1'b0;
         fail_b_reg <= 1'b0;
      end else begin
         fail_a_reg <= fail_a;
         fail_b_reg <= fail_b;
         if (por_busy_reg) begin
            switching_reg <= 1'b0;
         end else begin
            switching_reg <= (state_next != ST_RUN);
         end
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // every output comes straight from a flip-flop
   assign clock_out_o = out_reg;
   assign active_input_o = sel_cur_reg;
   assign switching_o = switching_reg;
   assign failed_a_o = fail_a_reg;
   assign failed_b_o = fail_b_reg;
   assign por_busy_o = por_busy_reg;

endmodule // gcsm_top

// ==== testbench/gcsm_top_monitor.sv ====
`timescale 1ns/1ps
module gcsm_top_monitor (
   // watched ports of the top
   input wire clk_sys_i, sys_rst_i, select_i, reset_delay_pin_i,
   input wire clock_out_o, active_input_o, switching_o, failed_a_o, failed_b_o, por_busy_o
);
   // ****************
   // switchover checks
   // ****************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   // failure state of the followed input and of the other one
   wire sel_dead = active_input_o ? failed_b_o : failed_a_o;
   wire new_dead = active_input_o ? failed_a_o : failed_b_o;
   por_quiet_a:
      assert property (por_busy_o |-> !clock_out_o && !switching_o)
      else $error("output moved during power-up hold");
   sel_sync_a:
      assert property ($changed(select_i) && !switching_o |=> !switching_o)
      else $error("select acted without synchroniser delay");
   switch_bound_a:
      assert property ($rose(switching_o) && !new_dead |-> ##[1:140] !switching_o)
      else $error("switchover took too long");
   end_toggle_a:
      assert property ($fell(switching_o) |-> active_input_o != $past(active_input_o))
      else $error("switchover ended without changing input");
   park_low_a:
      assert property ($fell(switching_o) |-> !$past(clock_out_o))
      else $error("output not parked low before following");
   active_end_a:
      assert property ($changed(active_input_o) && !por_busy_o && !$past(por_busy_o)
         && !reset_delay_pin_i && !$past(reset_delay_pin_i, 3) |-> $fell(switching_o))
      else $error("input changed outside a switchover");
   no_runt_hi_a:
      assert property ($rose(clock_out_o) && !reset_delay_pin_i |-> clock_out_o [*3])
      else $error("short high pulse on output");
   no_runt_lo_a:
      assert property ($fell(clock_out_o) && !reset_delay_pin_i |-> !clock_out_o [*3])
      else $error("short low pulse on output");
   hold_fail_a:
      assert property (!switching_o && !por_busy_o && sel_dead && $past(sel_dead)
         && $stable(active_input_o) |-> $stable(clock_out_o))
      else $error("output moved while followed input failed");
endmodule // gcsm_top_monitor

bind gcsm_top gcsm_top_monitor i_mon (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
   .select_i(select_i), .reset_delay_pin_i(reset_delay_pin_i), .clock_out_o(clock_out_o),
   .active_input_o(active_input_o), .switching_o(switching_o), .failed_a_o(failed_a_o),
   .failed_b_o(failed_b_o), .por_busy_o(por_busy_o));

// ==== testbench/gcsm_src_model.sv ====
`timescale 1ns/1ps
module gcsm_src_model #(
   parameter real HALF_NS = 40.0,
   parameter real SKEW_NS = 30.0
) (
   // fault mode: 0 run, 1 stuck high, 2 stuck low, 3 collapsed
   input wire [1:0] mode_a_i,
   input wire [1:0] mode_b_i,
   // source clocks and swing flags
   output wire clk_a_o,
   output wire clk_b_o,
   output wire amp_ok_a_o,
   output wire amp_ok_b_o
);
   reg run_a = 1'b0;
   reg run_b = 1'b0;
   reg noise = 1'b0;
   reg coll_a = 1'b0;
   reg coll_b = 1'b0;
   initial begin
      forever #(HALF_NS) run_a = ~run_a;
   end
   initial begin
      #(SKEW_NS);
      forever #(HALF_NS) run_b = ~run_b;
   end
   // collapsed source shows no clean level once the 50 ns noise lag has passed
   always #7 noise = ~noise;
   // noise lags the swing flag, as a comparator trips first
   always @(mode_a_i) coll_a <= #50 (mode_a_i == 2'h3);
   always @(mode_b_i) coll_b <= #50 (mode_b_i == 2'h3);
   assign clk_a_o = coll_a ? noise : mode_a_i == 2'h1 ? 1'b1 : mode_a_i == 2'h2 ? 1'b0 : run_a;
   assign clk_b_o = coll_b ? noise : mode_b_i == 2'h1 ? 1'b1 : mode_b_i == 2'h2 ? 1'b0 : run_b;
   assign amp_ok_a_o = (mode_a_i != 2'h3);
   assign amp_ok_b_o = (mode_b_i != 2'h3);
endmodule // gcsm_src_model

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
   // ****************
   // stimulus and design
   // ****************
   reg clk_sys = 1'b0;
   reg sys_rst = 1'b1;
   reg select = 1'b0;
   reg strap = 1'b0;
   reg [1:0] mode_a = 2'h0;
   reg [1:0] mode_b = 2'h0;
   wire clk_a, clk_b, amp_a, amp_b, clk_out, active, switching, fail_a, fail_b, por_busy;
   integer num_errors = 0;
   integer n_checks = 0;
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   gcsm_src_model i_src (.mode_a_i(mode_a), .mode_b_i(mode_b), .clk_a_o(clk_a),
      .clk_b_o(clk_b), .amp_ok_a_o(amp_a), .amp_ok_b_o(amp_b));
   // short power-up hold keeps the run brief
   gcsm_top #(.POR_CYCLES(16'h0010)) i_dut (.clk_sys_i(clk_sys), .sys_rst_i(sys_rst),
      .clock_input_a_i(clk_a), .clock_input_b_i(clk_b), .amp_ok_a_i(amp_a), .amp_ok_b_i(amp_b),
      .select_i(select), .reset_delay_pin_i(strap), .clock_out_o(clk_out),
      .active_input_o(active), .switching_o(switching), .failed_a_o(fail_a),
      .failed_b_o(fail_b), .por_busy_o(por_busy));
   // inputs move 1 ns after the edge
   task tick;
      begin
         @(posedge clk_sys);
         #1;
      end
   endtask
   task check(input [15:0] seen, input [15:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR %0t ns: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // guarded switch; start 2 skips the level check
   task do_switch(input sel, input [1:0] start);
      integer n;
      integer r;
      reg hi;
      reg last;
      begin
         n = 0;
         hi = 1'b0;
         select = sel;
         while (switching !== 1'b1 && n < 20) begin
            tick;
            n = n + 1;
         end
         check(n >= 3, 1'b1);
         check(switching, 1'b1);
         if (start != 2'h2) check(clk_out, start[0]);
         n = 0;
         while (switching === 1'b1 && n < 200) begin
            if (clk_out === 1'b1) hi = 1'b1;
            tick;
            n = n + 1;
         end
         check(n <= 136, 1'b1);
         check(active, sel);
         if (start == 2'h0) check(hi, 1'b0);
         check(clk_out, 1'b0);
         r = 0;
         last = clk_out;
         repeat (40) begin
            tick;
            if (clk_out === 1'b1 && last === 1'b0) r = r + 1;
            last = clk_out;
         end
         check(r >= 4, 1'b1);
      end
   endtask
   task t_por;
      integer n;
      begin
         repeat (20) tick;
         sys_rst = 1'b0;
         check(por_busy, 1'b1);
         n = 0;
         while (por_busy === 1'b1 && n < 100) begin
            check(clk_out, 1'b0);
            tick;
            n = n + 1;
         end
         check(n >= 16, 1'b1);
         $display("power-up hold done");
      end
   endtask
   task t_running;
      begin
         do_switch(1'b1, 2'h2);
         do_switch(1'b0, 2'h2);
         $display("running switchover done");
      end
   endtask
   task t_stuck_high;
      begin
         @(posedge clk_a);
         tick;
         mode_a = 2'h1;
         repeat (80) tick;
         check(fail_a, 1'b1);
         check(clk_out, 1'b1);
         do_switch(1'b1, 2'h1);
         mode_a = 2'h0;
         $display("stuck high done");
      end
   endtask
   task t_stuck_low;
      begin
         @(negedge clk_b);
         tick;
         mode_b = 2'h2;
         repeat (80) tick;
         check(fail_b, 1'b1);
         check(clk_out, 1'b0);
         do_switch(1'b0, 2'h0);
         mode_b = 2'h0;
         $display("stuck low done");
      end
   endtask
   task t_collapse;
      reg hold;
      begin
         mode_a = 2'h3;
         repeat (80) tick;
         check(fail_a, 1'b1);
         hold = clk_out;
         repeat (30) tick;
         check(clk_out, hold);
         do_switch(1'b1, {1'b0, hold});
         mode_a = 2'h0;
         $display("collapsed input done");
      end
   endtask
   task t_guard_off;
      integer n;
      integer r;
      reg seen;
      reg last;
      begin
         strap = 1'b1;
         repeat (8) tick;
         select = 1'b0;
         n = 0;
         seen = 1'b0;
         while (active !== 1'b0 && n < 20) begin
            if (switching === 1'b1) seen = 1'b1;
            tick;
            n = n + 1;
         end
         check(n <= 5, 1'b1);
         check(seen, 1'b0);
         // plain mux passes input a straight through
         r = 0;
         last = clk_out;
         repeat (40) begin
            tick;
            if (clk_out === 1'b1 && last === 1'b0) r = r + 1;
            last = clk_out;
         end
         check(r >= 4, 1'b1);
         $display("plain mux done");
      end
   endtask
   // ****************
   // run control
   // ****************
   task results;
      begin
         $display("checks %0d errors %0d", n_checks, num_errors);
         if (num_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
         end else begin
            $display("SIMULATION FAILED");
         end
         $finish;
      end
   endtask
   initial begin
      t_por;
      t_running;
      t_stuck_high;
      t_stuck_low;
      t_collapse;
      t_guard_off;
      results;
   end
   // tests need under 800 cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors = num_errors + 1;
      $display("ERROR %0t ns: watchdog expired", $time);
      results;
   end
endmodule // tb
